//--- hw/line_sync.sv
// Purpose: two-flop synchroniser with edge and condition detection
// Assumes: scl and sda sampled from pins on mclk
// Notes:   first flop read only by the second
`timescale 1ns/1ps
`default_nettype none

module line_sync
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// pins
	input  wire logic sclIn,
	input  wire logic sdaIn,
	// conditioned outputs
	output logic      sclLevel,
	output logic      sdaLevel,
	output logic      sclRise,
	output logic      sclFall,
	output logic      startSeen,
	output logic      stopSeen
);

	typedef struct packed
	{
		logic [1:0] sclMeta;
		logic [1:0] sdaMeta;
		logic       sclOld;
		logic       sdaOld;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.sclMeta = {s_q.sclMeta[0], sclIn};
		s_d.sdaMeta = {s_q.sdaMeta[0], sdaIn};
		s_d.sclOld  = s_q.sclMeta[1];
		s_d.sdaOld  = s_q.sdaMeta[1];
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s_q <= '{sclMeta: 2'b11, sdaMeta: 2'b11, sclOld: 1'b1, sdaOld: 1'b1};
		else
			s_q <= s_d;
	end

	assign sclLevel  = s_q.sclMeta[1];
	assign sdaLevel  = s_q.sdaMeta[1];
	assign sclRise   = s_q.sclMeta[1] & ~s_q.sclOld;
	assign sclFall   = ~s_q.sclMeta[1] & s_q.sclOld;
	assign startSeen = s_q.sclMeta[1] & s_q.sclOld & s_q.sdaOld & ~s_q.sdaMeta[1];
	assign stopSeen  = s_q.sclMeta[1] & s_q.sclOld & ~s_q.sdaOld & s_q.sdaMeta[1];

endmodule

`default_nettype wire

//--- hw/twowire_slave_transmit_status.sv
// Contract
// - own address read acked: flag, code A8
// - arbitration lost, own read: code B0
// - byte sent, acked: code B8
// - byte sent, not acked: code C0
// - last byte still acked: code C8
// - A8/B0/B8: load byte, clear flag
// - C0/C8 with ack off: fully unaddressed
// - ack on: own address, general call if enabled
// - start request: start when bus free
// - flag clear reports F8
// - F8: hardware waits or continues
// - misplaced start/stop reports 00
// - bus error sets service flag
// - recovery: unaddressed, stop bit self-clears
// - recovery releases lines, no stop sent
// - codes valid with prescaler bits zero
// - read direction enters transmit, else not
// - after last byte master gets ones
//
// Purpose: slave transmitter status and response logic over APB
// Assumes: pins sampled through line_sync; master owns scl
// Notes:   master side only requests a start; no master sequencer
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "twowire_st_defs.svh"

module twowire_slave_transmit_status
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// master side hooks
	input  wire logic        arbLostAddr,
	output logic             startIssue,
	// bus pins
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe
);
	import twowire_st_pkg::*;

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed
	{
		phase_e      phase;
		logic [3:0]  bitCnt;
		logic [7:0]  shift;
		logic [7:0]  status;
		logic        service;
		logic        ackEn;
		logic        startReq;
		logic        stopReq;
		logic        enable;
		logic        lastByte;
		logic        arbPend;
		logic        busBusy;
		logic [7:0]  dataReg;
		logic [7:0]  ownAddr;
		logic        sdaLow;
		logic        sclLow;
		logic        startPulse;
		logic [31:0] rdata;
		logic        ready;
		logic        slvErr;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic sclLevel;
	logic sdaLevel;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	line_sync u_sync
	(
		.mclk      (mclk),
		.rstn      (rstn),
		.sclIn     (sclIn),
		.sdaIn     (sdaIn),
		.sclLevel  (sclLevel),
		.sdaLevel  (sdaLevel),
		.sclRise   (sclRise),
		.sclFall   (sclFall),
		.startSeen (startSeen),
		.stopSeen  (stopSeen)
	);

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	logic       wrEn;
	logic       rdEn;
	logic       ctlWr;
	logic       clearFlag;
	logic       addrHit;
	logic       inFrame;
	logic [7:0] ctlView;

	always_comb
	begin
		s_d = s_q;
		s_d.startPulse = 1'b0;
		s_d.ready = 1'b0;
		wrEn = psel & penable & pwrite & ~s_q.ready;
		rdEn = psel & penable & ~pwrite & ~s_q.ready;
		ctlWr = wrEn & (paddr == `OFF_CONTROL);
		clearFlag = ctlWr & pwdata[`CTL_SERVICE];
		inFrame = (s_q.phase != PH_IDLE) && (s_q.phase != PH_IGNORE);
		addrHit = s_q.ackEn & s_q.enable &
			((s_q.shift[7:1] == s_q.ownAddr[7:1]) |
			(s_q.ownAddr[0] & (s_q.shift[7:1] == `GENCALL_ADDR)));
		ctlView = {s_q.service, s_q.ackEn, s_q.startReq, s_q.stopReq,
			1'b0, s_q.enable, 2'b00};

		// bus occupancy for start request
		if (startSeen)
			s_d.busBusy = 1'b1;
		if (stopSeen)
			s_d.busBusy = 1'b0;
		if (arbLostAddr)
			s_d.arbPend = 1'b1;

		// serial sequencer; idle while flag set holds the clock
		unique case (s_q.phase)
			PH_IDLE:
			begin
			end
			PH_ADDR:
				if (sclRise)
				begin
					s_d.shift = {s_q.shift[6:0], sdaLevel};
					s_d.bitCnt = s_q.bitCnt + 4'h1;
				end
				else if (sclFall && s_q.bitCnt == `BITS_PER_BYTE)
				begin
					if (addrHit && s_q.shift[0])
					begin
						s_d.sdaLow = 1'b1;
						s_d.phase = PH_ADRACK;
					end
					else
						s_d.phase = PH_IGNORE;
				end
			PH_ADRACK:
				if (sclFall)
				begin
					s_d.sdaLow = 1'b0;
					s_d.sclLow = 1'b1;
					s_d.service = 1'b1;
					s_d.status = s_q.arbPend ? `ST_ARB_READ : `ST_OWN_READ;
					s_d.arbPend = 1'b0;
					s_d.phase = PH_HOLD;
				end
			PH_HOLD:
			begin
			end
			PH_TXBIT:
				if (sclFall)
				begin
					if (s_q.bitCnt == `BITS_PER_BYTE - 4'h1)
					begin
						s_d.sdaLow = 1'b0;
						s_d.phase = PH_TXACK;
					end
					else
					begin
						s_d.shift = {s_q.shift[6:0], 1'b1};
						s_d.sdaLow = ~s_q.shift[6];
						s_d.bitCnt = s_q.bitCnt + 4'h1;
					end
				end
			PH_TXACK:
				if (sclRise)
				begin
					s_d.service = 1'b1;
					s_d.sclLow = 1'b0;
					if (sdaLevel)
						s_d.status = `ST_DATA_NACK;
					else if (s_q.lastByte)
						s_d.status = `ST_LAST_ACK;
					else
						s_d.status = `ST_DATA_ACK;
					s_d.bitCnt = `CTL_LAST_BIT;
				end
				else if (sclFall && s_q.bitCnt == `CTL_LAST_BIT)
				begin
					s_d.sclLow = 1'b1;
					s_d.phase = PH_HOLD;
				end
			PH_IGNORE:
			begin
			end
			default:
				s_d.phase = PH_IDLE;
		endcase

		// start and stop on the bus
		if (startSeen)
		begin
			if (inFrame && !(s_q.phase == PH_ADDR && s_q.bitCnt == 4'h0))
			begin
				s_d.service = 1'b1;
				s_d.status = `ST_BUS_ERROR;
				s_d.phase = PH_IDLE;
			end
			else
			begin
				s_d.phase = PH_ADDR;
				s_d.bitCnt = 4'h0;
				s_d.sdaLow = 1'b0;
			end
		end
		else if (stopSeen)
		begin
			if (s_q.phase == PH_ADDR || s_q.phase == PH_ADRACK || s_q.phase == PH_TXBIT ||
				s_q.phase == PH_TXACK)
			begin
				s_d.service = 1'b1;
				s_d.status = `ST_BUS_ERROR;
			end
			s_d.phase = PH_IDLE;
			s_d.sdaLow = 1'b0;
			s_d.sclLow = 1'b0;
		end

		// issue pending start once the bus is free
		if (s_q.startReq && !s_q.service && !s_q.busBusy && sclLevel && sdaLevel)
		begin
			s_d.startPulse = 1'b1;
			s_d.startReq = 1'b0;
		end

		// apb writes
		if (wrEn)
		begin
			unique case (paddr)
				`OFF_CONTROL:
				begin
					s_d.ackEn = pwdata[`CTL_ACKEN];
					s_d.startReq = pwdata[`CTL_START];
					s_d.stopReq = pwdata[`CTL_STOP];
					s_d.enable = pwdata[`CTL_ENABLE];
				end
				`OFF_DATA:    s_d.dataReg = pwdata[7:0];
				`OFF_OWNADDR: s_d.ownAddr = pwdata[7:0];
				default:
				begin
				end
			endcase
		end

		// software clears the flag: service the held status
		if (clearFlag && s_q.service && (s_d.status == s_q.status))
		begin
			s_d.service = 1'b0;
			s_d.sclLow = 1'b0;
			if (s_q.status == `ST_BUS_ERROR && pwdata[`CTL_STOP])
			begin
				s_d.stopReq = 1'b0;
				s_d.phase = PH_IDLE;
				s_d.sdaLow = 1'b0;
			end
			else if (s_q.status == `ST_OWN_READ || s_q.status == `ST_ARB_READ ||
				s_q.status == `ST_DATA_ACK)
			begin
				s_d.shift = s_q.dataReg;
				s_d.lastByte = ~pwdata[`CTL_ACKEN];
				s_d.sdaLow = ~s_q.dataReg[7];
				s_d.bitCnt = 4'h0;
				s_d.phase = PH_TXBIT;
			end
			else if (s_q.status == `ST_DATA_NACK || s_q.status == `ST_LAST_ACK)
			begin
				s_d.sdaLow = 1'b0;
				s_d.phase = PH_IGNORE;
			end
			s_d.status = `ST_IDLE;
		end

		// apb reads
		if (rdEn)
		begin
			unique case (paddr)
				`OFF_CONTROL: s_d.rdata = {24'h00_0000, ctlView};
				`OFF_STATUS:  s_d.rdata = {24'h00_0000, s_q.status & `PRESC_MASK};
				`OFF_DATA:    s_d.rdata = {24'h00_0000, s_q.dataReg};
				`OFF_OWNADDR: s_d.rdata = {24'h00_0000, s_q.ownAddr};
				default:      s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (psel && penable && !s_q.ready)
		begin
			s_d.ready = 1'b1;
			s_d.slvErr = ~((paddr == `OFF_CONTROL) | (paddr == `OFF_STATUS) |
				(paddr == `OFF_DATA) | (paddr == `OFF_OWNADDR));
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.phase <= PH_IDLE;
			s_q.status <= `ST_IDLE;
			s_q.dataReg <= `RESET_DATA;
			s_q.ownAddr <= `RESET_OWNADDR;
		end
		else
			s_q <= s_d;
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign prdata     = s_q.rdata;
	assign pready     = s_q.ready;
	assign pslverr    = s_q.slvErr;
	assign startIssue = s_q.startPulse;
	assign sclOut     = 1'b0;
	assign sclOe      = s_q.sclLow;
	assign sdaOut     = 1'b0;
	assign sdaOe      = s_q.sdaLow;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	flag_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
		!s_q.service |-> s_q.status == `ST_IDLE)
		else $error("flag clear but status not idle");

	hold_clock_a: assert property (@(posedge mclk) disable iff (!rstn)
		s_q.phase == PH_HOLD && s_q.service |-> sclOe)
		else $error("clock not held while flag set");

	bus_error_a: assert property (@(posedge mclk) disable iff (!rstn)
		startSeen && (s_q.phase == PH_TXBIT || (s_q.phase == PH_ADDR && s_q.bitCnt != 4'h0))
		|=> s_q.service && s_q.status == `ST_BUS_ERROR)
		else $error("bus error not flagged");

	recover_stop_a: assert property (@(posedge mclk) disable iff (!rstn)
		clearFlag && s_q.service && s_q.status == `ST_BUS_ERROR && pwdata[`CTL_STOP]
		&& !startSeen && !stopSeen |=> !s_q.stopReq && !sdaOe && !sclOe)
		else $error("bus error recovery incomplete");

	ack_code_a: assert property (@(posedge mclk) disable iff (!rstn)
		s_q.phase == PH_TXACK && sclRise && !sdaLevel && !s_q.lastByte && !startSeen
		&& !stopSeen |=> s_q.status == `ST_DATA_ACK)
		else $error("ack after byte not reported");

	nack_code_a: assert property (@(posedge mclk) disable iff (!rstn)
		s_q.phase == PH_TXACK && sclRise && sdaLevel && !startSeen
		&& !stopSeen |=> s_q.status == `ST_DATA_NACK)
		else $error("nack after byte not reported");

	ignore_ones_a: assert property (@(posedge mclk) disable iff (!rstn)
		s_q.phase == PH_IGNORE |-> !sdaOe)
		else $error("data driven while ignoring master");

	start_free_a: assert property (@(posedge mclk) disable iff (!rstn)
		startIssue |-> $past(s_q.startReq) && !s_q.startReq)
		else $error("start issued without request");

endmodule

`default_nettype wire

//--- hw/twowire_st_defs.svh
// Purpose: constants for the two-wire slave transmitter status block
// Assumes: APB byte addresses, 32-bit data words
// Notes:   offsets, fields, status codes and reset values
`ifndef TWOWIRE_ST_DEFS_SVH
`define TWOWIRE_ST_DEFS_SVH

// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define OFF_CONTROL    12'h000
`define OFF_STATUS     12'h004
`define OFF_DATA       12'h008
`define OFF_OWNADDR    12'h00C

// ---------------------------------------------
// control fields
// ---------------------------------------------
`define CTL_SERVICE    7
`define CTL_ACKEN      6
`define CTL_START      5
`define CTL_STOP       4
`define CTL_ENABLE     2

// ---------------------------------------------
// status codes and misc values
// ---------------------------------------------
`define ST_OWN_READ    8'hA8
`define ST_ARB_READ    8'hB0
`define ST_DATA_ACK    8'hB8
`define ST_DATA_NACK   8'hC0
`define ST_LAST_ACK    8'hC8
`define ST_IDLE        8'hF8
`define ST_BUS_ERROR   8'h00
`define PRESC_MASK     8'hF8
`define RESET_OWNADDR  8'h00
`define RESET_DATA     8'h00
`define GENCALL_ADDR   7'h00
`define BITS_PER_BYTE  4'h8
`define CTL_LAST_BIT   4'h9

`endif

//--- hw/twowire_st_pkg.sv
// Purpose: shared types for the two-wire slave transmitter block
// Assumes: constants come from the defs header
// Notes:   slave sequencer states
package twowire_st_pkg;

	typedef enum logic [2:0]
	{
		PH_IDLE   = 3'b000,
		PH_ADDR   = 3'b001,
		PH_ADRACK = 3'b010,
		PH_TXBIT  = 3'b011,
		PH_TXACK  = 3'b100,
		PH_HOLD   = 3'b101,
		PH_IGNORE = 3'b110
	} phase_e;

endpackage

//--- tb/tb_twowire_slave_transmit_status.sv
// Purpose: self-checking bench for the slave transmitter status block
// Assumes: APB master tasks, behavioural bus master receiver
// Notes:   random data from an lfsr with a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "twowire_st_defs.svh"

module tb_twowire_slave_transmit_status;
	import twowire_st_pkg::*;

	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic        arbLostAddr, startIssue, sclOut, sclOe, sdaOut, sdaOe;
	logic        sclLow, sdaLow, sclIn, sdaIn, a;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] seed = 32'h0000_7e62;
	logic [7:0]  d, r;
	logic [6:0]  own;
	int          miscompares = 0, total_checks = 0, cycles = 0, starts = 0;

	assign sclIn = ~(sclOe | sclLow);
	assign sdaIn = ~(sdaOe | sdaLow);

	twowire_slave_transmit_status i_twowire_slave_transmit_status
	(.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	 .arbLostAddr, .startIssue, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe);

	twowire_master_model master
	(.mclk(mclk), .sclLine(sclIn), .sdaLine(sdaIn), .sclLow(sclLow), .sdaLow(sdaLow));

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cycles++;
		if (startIssue === 1'b1)
			starts++;
		if (cycles == 20000)
		begin
			miscompares++;
			close_out;
		end
	end

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [7:0] afterByte(input logic last, input logic mAck);
		return !mAck ? `ST_DATA_NACK : (last ? `ST_LAST_ACK : `ST_DATA_ACK);
	endfunction

	task automatic close_out;
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdStat(input logic [7:0] e);
		apb(1'b0, `OFF_STATUS, 32'h0000_0000);
		chk(rd, {24'h0, e});
	endtask

	task automatic waitFlag;
		for (int i = 0; i < 40; i++)
		begin
			apb(1'b0, `OFF_CONTROL, 32'h0000_0000);
			if (rd[`CTL_SERVICE] === 1'b1)
				break;
		end
		chk({31'h0, rd[`CTL_SERVICE]}, 32'h0000_0001);
	endtask

	task automatic addrRead(input logic ackExp);
		master.start;
		master.xbyte({own, 1'b1}, r);
		master.xbit(1'b1, a);
		chk({31'h0, a}, {31'h0, ~ackExp});
	endtask

	task automatic xfer(input logic last, input logic mAck);
		seed = lfsr(seed);
		d = seed[7:0];
		apb(1'b1, `OFF_DATA, {24'h0, d});
		apb(1'b1, `OFF_CONTROL, last ? 32'h0000_0084 : 32'h0000_00C4);
		rdStat(`ST_IDLE);
		master.xbyte(8'hFF, r);
		chk({24'h0, r}, {24'h0, d});
		master.xbit(~mAck, a);
		waitFlag;
		rdStat(afterByte(last, mAck));
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		arbLostAddr = 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		rdStat(`ST_IDLE);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		seed = lfsr(seed);
		own = seed[6:0] | 7'h08;
		apb(1'b1, `OFF_OWNADDR, {24'h0, own, 1'b0});
		apb(1'b1, `OFF_CONTROL, 32'h0000_0044);
		addrRead(1'b1);
		waitFlag;
		rdStat(`ST_OWN_READ);
		chk({31'h0, sclOe}, 32'h0000_0001);
		xfer(1'b0, 1'b1);
		xfer(1'b1, 1'b1);
		apb(1'b1, `OFF_CONTROL, 32'h0000_0084);
		master.xbyte(8'hFF, r);
		chk({24'h0, r}, 32'h0000_00FF);
		master.xbit(1'b1, a);
		master.stop;
		addrRead(1'b0);
		master.stop;
		apb(1'b1, `OFF_CONTROL, 32'h0000_0044);
		apb(1'b1, `OFF_OWNADDR, {24'h0, own, 1'b1});
		own = `GENCALL_ADDR;
		arbLostAddr <= 1'b1;
		@(posedge mclk);
		arbLostAddr <= 1'b0;
		addrRead(1'b1);
		waitFlag;
		rdStat(`ST_ARB_READ);
		xfer(1'b1, 1'b0);
		apb(1'b1, `OFF_CONTROL, 32'h0000_00E4);
		chk(32'(starts), 32'h0000_0000);
		master.stop;
		for (int i = 0; i < 200 && starts == 0; i++)
			@(posedge mclk);
		chk(32'(starts), 32'h0000_0001);
		master.start;
		repeat (3) master.xbit(1'b1, a);
		master.start;
		waitFlag;
		rdStat(`ST_BUS_ERROR);
		apb(1'b1, `OFF_CONTROL, 32'h0000_00D4);
		apb(1'b0, `OFF_CONTROL, 32'h0000_0000);
		chk(rd & 32'h0000_00F4, 32'h0000_0044);
		chk({30'h0, sclOe, sdaOe}, 32'h0000_0000);
		chk({30'h0, sclOut, sdaOut}, 32'h0000_0000);
		master.stop;
		rdStat(`ST_IDLE);
		close_out;
	end
endmodule

`default_nettype wire

//--- tb/twowire_master_model.sv
// Purpose: behavioural two-wire master receiver
// Assumes: open-drain lines with pull-ups in the bench
// Notes:   bit period 9 mclk, honours clock stretching
`timescale 1ns/1ps
`default_nettype none

module twowire_master_model
(
	// clock
	input  wire logic mclk,
	// bus lines
	input  wire logic sclLine,
	input  wire logic sdaLine,
	output logic      sclLow,
	output logic      sdaLow
);
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// release clock, wait while slave stretches it
	task automatic sclRel;
		sclLow <= 1'b0;
		for (int i = 0; i < 3000 && sclLine !== 1'b1; i++)
			@(posedge mclk);
	endtask

	task automatic start;
		sdaLow <= 1'b0;
		wt(2);
		sclRel;
		wt(2);
		sdaLow <= 1'b1;
		wt(2);
		sclLow <= 1'b1;
		wt(2);
	endtask

	task automatic stop;
		sdaLow <= 1'b1;
		wt(2);
		sclRel;
		wt(2);
		sdaLow <= 1'b0;
		wt(4);
	endtask

	task automatic xbit(input logic b, output logic r);
		sdaLow <= ~b;
		wt(2);
		sclRel;
		wt(2);
		r = sdaLine;
		wt(2);
		sclLow <= 1'b1;
		wt(2);
	endtask

	task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r[i]);
	endtask
endmodule

`default_nettype wire
